// ===== rtl/hpio_map.svh
// Purpose: offsets, reset values and timing counts of the handler parallel io block
// Assumes: 40 MHz system clock
// Notes: times in ns, counts derived from the clock period
`ifndef HPIO_MAP_SVH
`define HPIO_MAP_SVH
// ****************************************
// clock and timing
// ****************************************
`define HPIO_CLK_PERIOD_NS 25
`define HPIO_STROBE_DELAY_NS 100
`define HPIO_STROBE_WIDTH_NS 1000
`define HPIO_TRIG_MIN_NS 1000
`define HPIO_USER_DELAY_NS 600
// least times round up, delay rounds down, none below one cycle
`define HPIO_STROBE_DELAY_CYC (`HPIO_STROBE_DELAY_NS / `HPIO_CLK_PERIOD_NS)
`define HPIO_STROBE_WIDTH_CYC \
   ((`HPIO_STROBE_WIDTH_NS + `HPIO_CLK_PERIOD_NS - 1) / `HPIO_CLK_PERIOD_NS)
`define HPIO_TRIG_MIN_CYC \
   ((`HPIO_TRIG_MIN_NS + `HPIO_CLK_PERIOD_NS - 1) / `HPIO_CLK_PERIOD_NS)
`define HPIO_USER_DELAY_CYC (`HPIO_USER_DELAY_NS / `HPIO_CLK_PERIOD_NS)
// ****************************************
// combined lane selectors and reset values
// ****************************************
`define HPIO_SEL_E 2'h0
`define HPIO_SEL_F 2'h1
`define HPIO_SEL_G 2'h2
`define HPIO_SEL_H 2'h3
`define HPIO_BIT_INDEX 6
`define HPIO_BIT_READY 7
`define HPIO_RST_AB_OUT 1'b1
`define HPIO_RST_CD_OUT 1'b0
`define HPIO_RST_LEVEL 1'b1
`endif

// ===== rtl/hpio_pkg.sv
// Purpose: types shared by the handler parallel io block
// Assumes: used with hpio_map.svh
// Notes: nothing is imported; use hpio_pkg::name
package hpio_pkg;
   // ****************************************
   // lane configuration and software write
   // ****************************************
   typedef struct packed {
      logic [3:0] dir_out;   // per lane a..d, 1 = output
      logic route_ctrl;      // index/ready replace lane b bits 6,7
      logic [1:0] follow;    // follow-input setting of user outputs
   } hpio_cfg_type;
   typedef struct packed {
      logic lane_we;         // one-cycle write of one base lane
      logic [1:0] lane_sel;  // 0..3 = a..d
      logic [7:0] lane_data;
      logic comb_we;         // one-cycle write of a combined lane
      logic [1:0] comb_sel;  // e, f, g, h
      logic [23:0] comb_data;
      logic [1:0] user_we;   // direct set of user outputs
      logic [1:0] user_level;
   } hpio_wr_type;
   typedef enum logic [1:0] {st_idle, st_delay, st_pulse} hpio_strobe_type;
endpackage

// ===== rtl/hpio_top.sv
// Purpose: handler parallel io: four lanes, combined views, user io, status lines
// Assumes: pins are active low as seen on the connector; sys_clk_i 40 MHz
// Notes: port data is kept in true logic, pins carry inverted levels
`timescale 1ns/1ps
`include "hpio_map.svh"

// Summary of operation
// RL1 - lanes set only by software configuration
// RL2 - lanes a and b are eight bits
// RL3 - routed indications replace lane b bits 6,7
// RL4 - combined 16-bit e and 8-bit f lanes
// RL5 - combined 20-bit g and 24-bit h lanes
// RL6 - combined bit order d, c, b, a
// RL7 - combined write only if members output
// RL8 - combined lanes read and written whole
// RL9 - slash signals are active low pins
// RL10 - user input low pulse sets outputs by follow
// RL11 - software sets user output levels directly
// RL12 - index goes low when sweeps are done
// RL13 - handler configures lanes before measuring
// RL14 - handler holds trigger low one microsecond
// RL15 - ready output low when trigger acceptable
// RL16 - write strobe one microsecond after 0.1 us
// RL17 - user input falling edges are recorded
// RL18 - every external input double synchronised
module hpio_top (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // software configuration and writes
   input wire hpio_pkg::hpio_cfg_type cfg_i,
   input wire hpio_pkg::hpio_wr_type wr_i,
   input wire logic [1:0] comb_rd_sel_i,
   input wire logic edge_clr_i,
   // measurement status
   input wire logic sweeps_done_i,
   input wire logic trig_ready_i,
   // lane pins, active low, three signals each
   input wire logic [23:0] lane_n_i,
   output logic [23:0] lane_n_o,
   output logic [23:0] lane_oe_o,
   // control pins, active low
   input wire logic user_in_n_i,
   input wire logic ext_trig_n_i,
   output logic [1:0] user_out_n_o,
   output logic wr_strobe_n_o,
   // results to software
   output logic [23:0] lane_rd_o,
   output logic [23:0] comb_rd_o,
   output logic comb_wr_refused_o,
   output logic user_edge_o,
   output logic trig_o
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [25:0] sync1;
   logic [25:0] sync2;
   logic [25:0] sync3;
   // three stages: the edge detectors read only the second and third
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sync1 <= 26'h3ff_ffff;
         sync2 <= 26'h3ff_ffff;
         sync3 <= 26'h3ff_ffff;
      end else begin
         sync1 <= {ext_trig_n_i, user_in_n_i, lane_n_i}; // RL18
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   logic [23:0] lane_in;
   logic user_fall;
   logic trig_low;
   assign lane_in = ~sync2[23:0];              // RL9
   assign user_fall = sync3[24] & ~sync2[24];  // RL17
   assign trig_low = ~sync2[25];

   // ****************************************
   // lane output registers
   // ****************************************
   logic [23:0] lane_out;
   logic [23:0] next_lane_out;
   logic [23:0] dir_mask;
   logic comb_ok;
   logic [23:0] comb_mask;
   logic any_write;
   // per-bit direction mask, lane order d c b a from msb (RL6)
   assign dir_mask = {{4{cfg_i.dir_out[3]}}, {4{cfg_i.dir_out[2]}},
                      {8{cfg_i.dir_out[1]}}, {8{cfg_i.dir_out[0]}}};
   always_comb begin
      comb_mask = 24'h00_0000;
      comb_ok = 1'b0;
      unique case (wr_i.comb_sel)
         `HPIO_SEL_E: begin
            comb_mask = 24'h00_ffff;            // RL4
            comb_ok = &cfg_i.dir_out[1:0];      // RL7
         end
         `HPIO_SEL_F: begin
            comb_mask = 24'hff_0000;            // RL4
            comb_ok = &cfg_i.dir_out[3:2];      // RL7
         end
         `HPIO_SEL_G: begin
            comb_mask = 24'h0f_ffff;            // RL5
            comb_ok = &cfg_i.dir_out[2:0];      // RL7
         end
         `HPIO_SEL_H: begin
            comb_mask = 24'hff_ffff;            // RL5
            comb_ok = &cfg_i.dir_out;           // RL7
         end
      endcase
   end
   // only software writes move lane data; nothing from the measurement does
   always_comb begin
      next_lane_out = lane_out;
      any_write = 1'b0;
      if (wr_i.lane_we) begin
         any_write = 1'b1;
         unique case (wr_i.lane_sel)
            2'h0: next_lane_out[7:0] = wr_i.lane_data;        // RL2
            2'h1: next_lane_out[15:8] = wr_i.lane_data;       // RL2
            2'h2: next_lane_out[19:16] = wr_i.lane_data[3:0];
            2'h3: next_lane_out[23:20] = wr_i.lane_data[3:0];
         endcase
      end else if (wr_i.comb_we && comb_ok) begin
         any_write = 1'b1;
         // combined value packed from bit 0: f's data is shifted up to lanes c,d
         if (wr_i.comb_sel == `HPIO_SEL_F) begin
            next_lane_out[23:16] = wr_i.comb_data[7:0];       // RL8
         end else begin
            next_lane_out = (lane_out & ~comb_mask) | (wr_i.comb_data & comb_mask); // RL8
         end
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         lane_out <= 24'h00_0000;  // logic 0 shows high on the pins
      end else begin
         lane_out <= next_lane_out; // RL1
      end
   end

   // ****************************************
   // pin drive, routing of index and ready
   // ****************************************
   logic [23:0] pin_val;
   logic [23:0] pin_oe;
   always_comb begin
      pin_val = lane_out;
      pin_oe = dir_mask;
      if (cfg_i.route_ctrl) begin
         // lane b keeps six bits; top two carry status
         pin_val[8 + `HPIO_BIT_INDEX] = sweeps_done_i; // RL3 RL12
         pin_val[8 + `HPIO_BIT_READY] = trig_ready_i;  // RL3 RL15
         pin_oe[8 + `HPIO_BIT_INDEX] = 1'b1;
         pin_oe[8 + `HPIO_BIT_READY] = 1'b1;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         lane_n_o <= 24'hff_ffff;
         lane_oe_o <= 24'h00_0000;
      end else begin
         lane_n_o <= ~pin_val;  // RL9
         lane_oe_o <= pin_oe;
      end
   end

   // ****************************************
   // read back of lanes and combined lanes
   // ****************************************
   logic [23:0] lane_view;
   logic [23:0] comb_view;
   assign lane_view = (lane_out & dir_mask) | (lane_in & ~dir_mask);
   always_comb begin
      unique case (comb_rd_sel_i)
         `HPIO_SEL_E: comb_view = {8'h00, lane_view[15:0]};   // RL8
         `HPIO_SEL_F: comb_view = {16'h0000, lane_view[23:16]};
         `HPIO_SEL_G: comb_view = {4'h0, lane_view[19:0]};
         `HPIO_SEL_H: comb_view = lane_view;                  // RL6
      endcase
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         lane_rd_o <= 24'h00_0000;
         comb_rd_o <= 24'h00_0000;
         comb_wr_refused_o <= 1'b0;
      end else begin
         lane_rd_o <= lane_view;
         comb_rd_o <= comb_view;
         comb_wr_refused_o <= wr_i.comb_we & ~comb_ok;  // RL7
      end
   end

   // ****************************************
   // write strobe: delay then low pulse
   // ****************************************
   localparam int unsigned DLY = `HPIO_STROBE_DELAY_CYC;
   localparam int unsigned WID = `HPIO_STROBE_WIDTH_CYC;
   hpio_pkg::hpio_strobe_type st;
   hpio_pkg::hpio_strobe_type next_st;
   logic [5:0] st_cnt;
   logic [5:0] next_st_cnt;
   // a new write restarts the sequence, so a write during a pulse cuts that pulse short
   always_comb begin
      next_st = st;
      next_st_cnt = st_cnt + 6'd1;
      if (any_write) begin
         next_st = hpio_pkg::st_delay;
         next_st_cnt = 6'd1;
      end else begin
         unique case (st)
            hpio_pkg::st_idle: next_st_cnt = 6'd0;
            hpio_pkg::st_delay: if (st_cnt == 6'(DLY)) begin
               next_st = hpio_pkg::st_pulse;
               next_st_cnt = 6'd1;
            end
            hpio_pkg::st_pulse: if (st_cnt == 6'(WID)) begin
               next_st = hpio_pkg::st_idle;
               next_st_cnt = 6'd0;
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st <= hpio_pkg::st_idle;
         st_cnt <= 6'd0;
      end else begin
         st <= next_st;   // RL16
         st_cnt <= next_st_cnt;
      end
   end
   assign wr_strobe_n_o = (st != hpio_pkg::st_pulse); // RL16

   // ****************************************
   // user input, outputs, trigger qualification
   // ****************************************
   logic [1:0] user_lvl;
   logic [1:0] next_user_lvl;
   logic [4:0] user_cnt;
   logic [4:0] next_user_cnt;
   logic user_edge;
   logic next_user_edge;
   logic [5:0] trig_cnt;
   logic [5:0] next_trig_cnt;
   logic next_trig;
   localparam int unsigned UDL = `HPIO_USER_DELAY_CYC;
   localparam int unsigned TMIN = `HPIO_TRIG_MIN_CYC;
   // follow action lands about 0.6 us after the input edge
   always_comb begin
      next_user_lvl = user_lvl;
      next_user_cnt = (user_cnt != 5'd0) ? user_cnt - 5'd1 : 5'd0;
      next_user_edge = user_edge & ~edge_clr_i;
      if (user_fall) begin
         next_user_edge = 1'b1;           // RL17 set wins over clear
         next_user_cnt = 5'(UDL);
      end
      if (user_cnt == 5'd1) begin
         // follow 1 drives low (logic 1), follow 0 drives high
         next_user_lvl = cfg_i.follow;    // RL10
      end
      for (int i = 0; i < 2; i++) begin
         if (wr_i.user_we[i]) begin
            next_user_lvl[i] = wr_i.user_level[i]; // RL11
         end
      end
      next_trig_cnt = trig_low ? ((trig_cnt == 6'(TMIN)) ? trig_cnt : trig_cnt + 6'd1)
                               : 6'd0;
      next_trig = trig_low && (trig_cnt == 6'(TMIN - 1));
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         user_lvl <= 2'b00;
         user_cnt <= 5'd0;
         user_edge <= 1'b0;
         trig_cnt <= 6'd0;
         trig_o <= 1'b0;
      end else begin
         user_lvl <= next_user_lvl;
         user_cnt <= next_user_cnt;
         user_edge <= next_user_edge;
         trig_cnt <= next_trig_cnt;   // RL14
         trig_o <= next_trig;
      end
   end
   assign user_out_n_o = ~user_lvl;   // RL9
   assign user_edge_o = user_edge;

   // ****************************************
   // checks
   // ****************************************
   // strobe low time counted, since forty cycles is too long to repeat in a property
   logic [5:0] low_run;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || wr_strobe_n_o) begin
         low_run <= 6'd0;
      end else begin
         low_run <= low_run + 6'd1;
      end
   end
   a_strobe_width: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL16
      $rose(wr_strobe_n_o) && st == hpio_pkg::st_idle |-> low_run == 6'(WID))
      else $error("write strobe not one microsecond long");
   a_strobe_delay: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL16
      any_write |=> wr_strobe_n_o [*4] ##1 (!wr_strobe_n_o || st == hpio_pkg::st_delay))
      else $error("write strobe not after the delay");
   a_comb_refuse: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL7
      wr_i.comb_we && !comb_ok && !wr_i.lane_we |=> $stable(lane_out))
      else $error("combined write changed lanes with an input member");
   a_lane_stable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL1
      !wr_i.lane_we && !wr_i.comb_we |=> $stable(lane_out))
      else $error("lane data changed without a write");
   a_index_route: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL3
      cfg_i.route_ctrl |=> lane_n_o[14] == !$past(sweeps_done_i))
      else $error("index not on lane b bit six");
   a_ready_route: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL15
      cfg_i.route_ctrl |=> lane_n_o[15] == !$past(trig_ready_i))
      else $error("ready not on lane b bit seven");
   a_edge_record: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL17
      user_fall |=> user_edge_o)
      else $error("user input edge not recorded");
   a_user_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL10
      user_cnt == 5'd1 && wr_i.user_we == 2'b00 |=> user_out_n_o == ~$past(cfg_i.follow))
      else $error("user output did not follow the input pulse");
   a_user_direct: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL11
      wr_i.user_we == 2'b11 |=> user_out_n_o == ~$past(wr_i.user_level))
      else $error("direct user level not applied");
   a_lane_pins: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RL9
      !cfg_i.route_ctrl |=> lane_n_o[7:0] == ~$past(lane_out[7:0]))
      else $error("lane a pins not inverted data");
   c_comb_write: cover property (@(posedge sys_clk_i) wr_i.comb_we && comb_ok);
   c_strobe: cover property (@(posedge sys_clk_i) $rose(wr_strobe_n_o));
   c_trigger: cover property (@(posedge sys_clk_i) trig_o);
   c_follow: cover property (@(posedge sys_clk_i) user_cnt == 5'd1);
endmodule

// ===== verification/hpio_handler_model.sv
// Purpose: part handler model on the far side of the handler io pins
// Assumes: pins are active low, the device drives a lane bit while its enable is high
// Notes: pulses are started by the bench through the two tasks
`timescale 1ns/1ps
module hpio_handler_model (
   // clock
   input wire logic sys_clk_i,
   // device side of the lane pins
   input wire logic [23:0] dev_n_i,
   input wire logic [23:0] dev_oe_i,
   input wire logic [23:0] drv_n_i,
   // wire levels back to the device
   output logic [23:0] pin_n_o,
   output logic user_in_n_o,
   output logic ext_trig_n_o
);
   // the wire level: the device wins where it drives, the handler elsewhere
   assign pin_n_o = (dev_oe_i & dev_n_i) | (~dev_oe_i & drv_n_i);
   // idle levels of the handler's own lines
   initial begin
      user_in_n_o = 1'b1;
      ext_trig_n_o = 1'b1;
   end
   // trigger held low for n cycles; a short hold is only used when asked for
   task automatic pulse_trig(input int n);
      @(posedge sys_clk_i);
      ext_trig_n_o <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      ext_trig_n_o <= 1'b1;
   endtask
   // negative pulse on the user input
   task automatic pulse_user(input int n);
      @(posedge sys_clk_i);
      user_in_n_o <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      user_in_n_o <= 1'b1;
   endtask
endmodule

// ===== verification/hpio_top_tb.sv
// Purpose: self-checking bench of the handler parallel io block
// Assumes: hpio_handler_model stands on the lane and control pins
// Notes: drivers note expected values in a queue, a monitor compares them
`timescale 1ns/1ps
module hpio_top_tb;
   typedef struct {int k; logic [23:0] v;} hpio_note_type;
   // ****************************************
   // signals and instances
   // ****************************************
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   hpio_pkg::hpio_cfg_type cfg = '0;
   hpio_pkg::hpio_wr_type wr = '0;
   logic [1:0] rd_sel = 2'h0;
   logic edge_clr = 1'b0, sweeps_done = 1'b0, trig_ready = 1'b0;
   logic [23:0] drv_n = 24'hff_ffff, d, e, pat, got;
   wire [23:0] pin_n, lane_n_o, lane_oe_o, lane_rd_o, comb_rd_o;
   wire [1:0] user_out_n;
   wire user_in_n, ext_trig_n, strobe_n, refused, user_edge, trig;
   hpio_note_type exp_q[$];
   hpio_note_type n;
   event chk_ev;
   int failures = 0, check_count = 0, ref_cnt = 0, trig_cnt = 0, cycles = 0;
   string names[9] = '{"lane_n_o", "lane_rd_o", "comb_rd_o", "lane_oe_o", "user_out_n_o",
      "wr_strobe_n_o", "user_edge_o", "refused count", "trigger count"};
   hpio_top u_hpio_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cfg_i(cfg), .wr_i(wr),
      .comb_rd_sel_i(rd_sel), .edge_clr_i(edge_clr), .sweeps_done_i(sweeps_done),
      .trig_ready_i(trig_ready), .lane_n_i(pin_n), .lane_n_o(lane_n_o), .lane_oe_o(lane_oe_o),
      .user_in_n_i(user_in_n), .ext_trig_n_i(ext_trig_n), .user_out_n_o(user_out_n),
      .wr_strobe_n_o(strobe_n), .lane_rd_o(lane_rd_o), .comb_rd_o(comb_rd_o),
      .comb_wr_refused_o(refused), .user_edge_o(user_edge), .trig_o(trig));
   hpio_handler_model u_hpio_handler_model (.sys_clk_i(sys_clk_i), .dev_n_i(lane_n_o),
      .dev_oe_i(lane_oe_o), .drv_n_i(drv_n), .pin_n_o(pin_n), .user_in_n_o(user_in_n),
      .ext_trig_n_o(ext_trig_n));
   // ****************************************
   // helpers
   // ****************************************
   // clock, 25 ns period
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   // pulse counters and the hang limit, well above the few hundred cycles needed
   always @(posedge sys_clk_i) begin
      cycles++;
      if (refused === 1'b1) ref_cnt++;
      if (trig === 1'b1) trig_cnt++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic note(input int k, input logic [23:0] v);
      exp_q.push_back('{k, v});
      -> chk_ev;
   endtask
   task automatic check_vec(input string s, input logic [23:0] x, input logic [23:0] y);
      check_count++;
      if (x !== y) begin
         failures++;
         $display("Error %s expected %h seen %h", s, x, y);
      end
   endtask
   task automatic check_bit(input string s, input logic x, input logic y);
      check_count++;
      if (x !== y) begin
         failures++;
         $display("Error %s expected %b seen %b", s, x, y);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // write strobes are single cycles, so the second edge is the taking edge
   task automatic write_comb(input logic [1:0] s, input logic [23:0] v);
      @(posedge sys_clk_i);
      wr.comb_we <= 1'b1;
      wr.comb_sel <= s;
      wr.comb_data <= v;
      @(posedge sys_clk_i);
      wr.comb_we <= 1'b0;
   endtask
   task automatic write_lane(input logic [1:0] s, input logic [7:0] v);
      @(posedge sys_clk_i);
      wr.lane_we <= 1'b1;
      wr.lane_sel <= s;
      wr.lane_data <= v;
      @(posedge sys_clk_i);
      wr.lane_we <= 1'b0;
   endtask
   // monitor: takes the oldest note and compares it with the output it names
   always begin
      @(chk_ev);
      while (exp_q.size() > 0) begin
         n = exp_q.pop_front();
         case (n.k)
            0: got = lane_n_o;
            1: got = lane_rd_o;
            2: got = comb_rd_o;
            3: got = lane_oe_o;
            4: got = {22'h0, user_out_n};
            5: got = {23'h0, strobe_n};
            6: got = {23'h0, user_edge};
            7: got = 24'(ref_cnt);
            default: got = 24'(trig_cnt);
         endcase
         if (n.k == 5 || n.k == 6) check_bit(names[n.k], n.v[0], got[0]);
         else check_vec(names[n.k], n.v, got);
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int r0;
      logic [23:0] s_exp[4];
      void'($urandom(32'hf824));
      repeat (4) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      tick(1);
      note(0, 24'hff_ffff);
      note(3, 24'h00_0000);
      note(4, 24'h00_0003);
      note(5, 24'h00_0001);
      // lanes are set up before any measurement activity
      @(posedge sys_clk_i) cfg.dir_out <= 4'hf;
      d = 24'($urandom);
      write_comb(2'h3, d);
      tick(2);
      note(0, ~d);
      note(3, 24'hff_ffff);
      note(1, d);
      s_exp = '{{8'h0, d[15:0]}, {16'h0, d[23:16]}, {4'h0, d[19:0]}, d};
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk_i) rd_sel <= 2'(i);
         tick(3);
         note(2, s_exp[i]);
      end
      tick(40);
      e = 24'($urandom);
      write_lane(2'h1, e[7:0]);
      tick(2);
      d[15:8] = e[7:0];
      note(0, ~d);
      note(1, d);
      note(5, 24'h1);
      tick(8);
      note(5, 24'h0);
      tick(30);
      note(5, 24'h0);
      tick(12);
      note(5, 24'h1);
      // routed indications take bits 6 and 7 of lane b, the rest stays a lane
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk_i);
         cfg.route_ctrl <= 1'b1;
         sweeps_done <= (i == 0);
         trig_ready <= (i == 1);
         tick(5);
         note(0, {~d[23:16], (i == 0), (i == 1), ~d[13:0]});
      end
      @(posedge sys_clk_i) cfg.route_ctrl <= 1'b0;
      // lane c turned input: a write of G is refused, E still taken
      pat = 24'($urandom);
      @(posedge sys_clk_i);
      cfg.dir_out <= 4'b1011;
      drv_n <= pat;
      tick(5);
      r0 = ref_cnt;
      write_comb(2'h2, 24'($urandom));
      tick(4);
      note(7, 24'(r0 + 1));
      note(3, 24'hf0_ffff);
      note(1, {d[23:20], ~pat[19:16], d[15:0]});
      e = 24'($urandom);
      write_comb(2'h0, e);
      tick(4);
      note(7, 24'(r0 + 1));
      note(1, {d[23:20], ~pat[19:16], e[15:0]});
      // lanes c,d back to output: an F write lands on c,d, then a lane d write on d only
      @(posedge sys_clk_i) cfg.dir_out <= 4'hf;
      pat = 24'($urandom);
      write_comb(2'h1, pat);
      write_lane(2'h3, pat[15:8]);
      tick(4);
      note(1, {pat[11:8], pat[3:0], e[15:0]});
      note(2, {pat[11:8], pat[3:0], e[15:0]});
      // user outputs: direct set, then follow an input pulse
      @(posedge sys_clk_i);
      wr.user_we <= 2'b11;
      wr.user_level <= 2'b10;
      @(posedge sys_clk_i);
      wr.user_we <= 2'b00;
      tick(3);
      note(4, 24'h1);
      @(posedge sys_clk_i) cfg.follow <= 2'b01;
      u_hpio_handler_model.pulse_user(4);
      tick(40);
      note(4, 24'h2);
      note(6, 24'h1);
      @(posedge sys_clk_i) edge_clr <= 1'b1;
      @(posedge sys_clk_i) edge_clr <= 1'b0;
      tick(3);
      note(6, 24'h0);
      // trigger: a full hold gives one pulse, a short one none
      r0 = trig_cnt;
      u_hpio_handler_model.pulse_trig(60);
      tick(6);
      note(8, 24'(r0 + 1));
      u_hpio_handler_model.pulse_trig(20);
      tick(6);
      note(8, 24'(r0 + 1));
      tick(2);
      final_report();
   end
endmodule
